// >>> rtl/pwm_interrupt_and_clear_control.sv
// Purpose: interrupt enable/flags, capture latch indicators, counter readback
// Assumes: events and counter values come from logic on clk_in
// Notes: avalon-mm slave answers one cycle after taking a request
// Operation
// R1: one bit picks whether writing 0 or writing 1 clears latch indicators.
// R2: interrupt enable register holds one enable bit per channel, bit n.
// R3: zero-reached sets channel flag bit n when its enable bit is one.
// R4: writing 1 to a flag bit clears only that flag.
// R5: each channel's 16-bit down counter value is readable by software.
// R6: capture rising or falling latch sets that channel's latch indicator.
// R7: group interrupt is high while any channel flag is set.
`timescale 1ns/100ps
module pwm_interrupt_and_clear_control
    import pwm_irq_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [DATA_W-1:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [DATA_W-1:0] readdata_out,
    output logic waitrequest_out,
    input wire chan_events_s events_in,
    input wire counters_t counters_in,
    output logic [NUM_CH-1:0] rising_latch_indicator_out,
    output logic [NUM_CH-1:0] falling_latch_indicator_out,
    output logic group_irq_out,
    output logic event_irq_out
);
    // ====================================================
    // state
    bus_state_e bus_state;
    logic clear_polarity_select;
    logic [NUM_CH-1:0] irq_enable;
    logic [NUM_CH-1:0] irq_flag;
    logic [NUM_CH-1:0] rising_latch_indicator;
    logic [NUM_CH-1:0] falling_latch_indicator;
    logic [EV_W-1:0] event_status;
    logic [EV_W-1:0] event_mask;
    logic [NUM_CH-1:0] next_irq_flag;
    logic [NUM_CH-1:0] next_rise_ind;
    logic [NUM_CH-1:0] next_fall_ind;
    logic [EV_W-1:0] next_event_status;
    logic [NUM_CH-1:0] flag_set;
    logic [EV_W-1:0] event_pulses;
    logic wr_commit;
    logic rd_commit;
    logic lane0;
    logic [DATA_W-1:0] read_value;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // commit happens at the edge where the master sees waitrequest low
    assign wr_commit = write_in && !waitrequest_out;
    assign rd_commit = read_in && !waitrequest_out;
    assign lane0 = byteenable_in[0];

    // ====================================================
    // bus handshake
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_state <= BUS_IDLE;
            waitrequest_out <= 1'b1;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (read_in || write_in) begin
                        bus_state <= BUS_ACK;
                        waitrequest_out <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_state <= BUS_IDLE;
                    waitrequest_out <= 1'b1;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                    waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    // ====================================================
    // read mux
    always_comb begin
        read_value = RST_READDATA;
        if (hit(address_in, OFF_COUNTER_READBACK_0)) begin
            read_value[CNT_W-1:0] = counters_in[0]; // R5
        end else if (hit(address_in, OFF_COUNTER_READBACK_1)) begin
            read_value[CNT_W-1:0] = counters_in[1]; // R5
        end else if (hit(address_in, OFF_COUNTER_READBACK_2)) begin
            read_value[CNT_W-1:0] = counters_in[2]; // R5
        end else if (hit(address_in, OFF_COUNTER_READBACK_3)) begin
            read_value[CNT_W-1:0] = counters_in[3]; // R5
        end else if (hit(address_in, OFF_CAPTURE_CLEAR_POLARITY)) begin
            read_value[POS_CLEAR_POLARITY_SELECT] = clear_polarity_select;
        end else if (hit(address_in, OFF_CHANNEL_INTERRUPT_ENABLE)) begin
            read_value[NUM_CH-1:0] = irq_enable;
        end else if (hit(address_in, OFF_CHANNEL_INTERRUPT_FLAGS)) begin
            read_value[NUM_CH-1:0] = irq_flag;
        end else if (hit(address_in, OFF_LATCH_INDICATORS)) begin
            read_value[POS_RISING_LATCH_INDICATOR +: NUM_CH] =
                rising_latch_indicator;
            read_value[POS_FALLING_LATCH_INDICATOR +: NUM_CH] =
                falling_latch_indicator;
        end else if (hit(address_in, OFF_EVENT_STATUS)) begin
            read_value[EV_W-1:0] = event_status;
        end else if (hit(address_in, OFF_EVENT_MASK)) begin
            read_value[EV_W-1:0] = event_mask;
        end
    end

    // readdata sampled as waitrequest drops, held through the commit edge
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            readdata_out <= RST_READDATA;
        end else if (bus_state == BUS_IDLE && read_in) begin
            readdata_out <= read_value;
        end
    end

    // ====================================================
    // control registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            clear_polarity_select <= RST_CLEAR_POLARITY;
            irq_enable <= RST_IRQ_ENABLE;
            event_mask <= RST_EVENTS;
        end else if (wr_commit && lane0) begin
            if (hit(address_in, OFF_CAPTURE_CLEAR_POLARITY)) begin
                clear_polarity_select <=
                    writedata_in[POS_CLEAR_POLARITY_SELECT]; // R1
            end else if (hit(address_in, OFF_CHANNEL_INTERRUPT_ENABLE)) begin
                irq_enable <= writedata_in[NUM_CH-1:0]; // R2
            end else if (hit(address_in, OFF_EVENT_MASK)) begin
                event_mask <= writedata_in[EV_W-1:0];
            end
        end
    end

    // ====================================================
    // channel flags; a set in the clearing cycle wins
    assign flag_set = events_in.zero_reached & irq_enable; // R3
    always_comb begin
        next_irq_flag = irq_flag;
        if (wr_commit && lane0 &&
            hit(address_in, OFF_CHANNEL_INTERRUPT_FLAGS)) begin
            next_irq_flag = irq_flag & ~writedata_in[NUM_CH-1:0]; // R4
        end
        next_irq_flag = next_irq_flag | flag_set; // R3
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_flag <= RST_IRQ_FLAGS;
            group_irq_out <= 1'b0;
        end else begin
            irq_flag <= next_irq_flag;
            group_irq_out <= |next_irq_flag; // R7
        end
    end

    // ====================================================
    // capture latch indicators, clear polarity chosen by software
    always_comb begin
        next_rise_ind = rising_latch_indicator;
        next_fall_ind = falling_latch_indicator;
        if (wr_commit && lane0 && hit(address_in, OFF_LATCH_INDICATORS)) begin
            if (clear_polarity_select) begin
                next_rise_ind = rising_latch_indicator &
                    ~writedata_in[POS_RISING_LATCH_INDICATOR +: NUM_CH]; // R1
                next_fall_ind = falling_latch_indicator &
                    ~writedata_in[POS_FALLING_LATCH_INDICATOR +: NUM_CH];
            end else begin
                next_rise_ind = rising_latch_indicator &
                    writedata_in[POS_RISING_LATCH_INDICATOR +: NUM_CH]; // R1
                next_fall_ind = falling_latch_indicator &
                    writedata_in[POS_FALLING_LATCH_INDICATOR +: NUM_CH];
            end
        end
        next_rise_ind = next_rise_ind | events_in.rise_latched; // R6
        next_fall_ind = next_fall_ind | events_in.fall_latched; // R6
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rising_latch_indicator <= RST_LATCH_IND;
            falling_latch_indicator <= RST_LATCH_IND;
            rising_latch_indicator_out <= RST_LATCH_IND;
            falling_latch_indicator_out <= RST_LATCH_IND;
        end else begin
            rising_latch_indicator <= next_rise_ind;
            falling_latch_indicator <= next_fall_ind;
            rising_latch_indicator_out <= next_rise_ind;
            falling_latch_indicator_out <= next_fall_ind;
        end
    end

    // ====================================================
    // sticky event status, cleared by reading it
    assign event_pulses[POS_EV_ZERO +: NUM_CH] = events_in.zero_reached;
    assign event_pulses[POS_EV_RISE +: NUM_CH] = events_in.rise_latched;
    assign event_pulses[POS_EV_FALL +: NUM_CH] = events_in.fall_latched;
    always_comb begin
        next_event_status = event_status;
        if (rd_commit && hit(address_in, OFF_EVENT_STATUS)) begin
            next_event_status = RST_EVENTS;
        end
        next_event_status = next_event_status | event_pulses;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            event_status <= RST_EVENTS;
            event_irq_out <= 1'b0;
        end else begin
            event_status <= next_event_status;
            event_irq_out <= |(next_event_status & event_mask);
        end
    end

    // ====================================================
    // checks
    logic [CNT_W-1:0] counter0;
    assign counter0 = counters_in[0];

    property p_polarity_zero_clear;
        @(posedge clk_in) disable iff (reset_in)
        (wr_commit && lane0 && hit(address_in, OFF_LATCH_INDICATORS) &&
         !clear_polarity_select && !writedata_in[0] &&
         !events_in.rise_latched[0]) |=> !rising_latch_indicator[0];
    endproperty
    a_polarity_zero_clear: assert property (p_polarity_zero_clear) // R1
        else $error("latch indicator not cleared by writing zero");

    property p_enable_write;
        @(posedge clk_in) disable iff (reset_in)
        (wr_commit && lane0 && hit(address_in, OFF_CHANNEL_INTERRUPT_ENABLE))
        |=> (irq_enable == $past(writedata_in[NUM_CH-1:0]));
    endproperty
    a_enable_write: assert property (p_enable_write) // R2
        else $error("interrupt enable did not take written value");

    property p_flag_set;
        @(posedge clk_in) disable iff (reset_in)
        (events_in.zero_reached[2] && irq_enable[2]) |=> irq_flag[2]
            ##1 (irq_flag[2] || $past(wr_commit));
    endproperty
    a_flag_set: assert property (p_flag_set) // R3
        else $error("enabled zero-reached did not set its flag");

    property p_flag_w1c;
        @(posedge clk_in) disable iff (reset_in)
        (wr_commit && lane0 && hit(address_in, OFF_CHANNEL_INTERRUPT_FLAGS) &&
         writedata_in[0] && !writedata_in[1] && !flag_set[0])
        |=> (!irq_flag[0] && (irq_flag[1] || !$past(irq_flag[1])));
    endproperty
    a_flag_w1c: assert property (p_flag_w1c) // R4
        else $error("flag write-one-to-clear misbehaved");

    property p_counter_read;
        @(posedge clk_in) disable iff (reset_in)
        (bus_state == BUS_IDLE && read_in &&
         hit(address_in, OFF_COUNTER_READBACK_0))
        |=> (readdata_out == {16'h0000, $past(counter0)}) && !waitrequest_out;
    endproperty
    a_counter_read: assert property (p_counter_read) // R5
        else $error("counter readback wrong");

    property p_latch_set;
        @(posedge clk_in) disable iff (reset_in)
        events_in.fall_latched[1] |=> falling_latch_indicator[1] &&
            falling_latch_indicator_out[1];
    endproperty
    a_latch_set: assert property (p_latch_set) // R6
        else $error("capture latch did not set indicator");

    property p_group_irq;
        @(posedge clk_in) disable iff (reset_in)
        group_irq_out == (irq_flag != 4'h0);
    endproperty
    a_group_irq: assert property (p_group_irq) // R7
        else $error("group interrupt disagrees with flags");

    property p_event_irq;
        @(posedge clk_in) disable iff (reset_in)
        events_in.zero_reached[0] && event_mask[POS_EV_ZERO] &&
        !(wr_commit && hit(address_in, OFF_EVENT_MASK)) |=> event_irq_out;
    endproperty
    a_event_irq: assert property (p_event_irq)
        else $error("masked-in event did not raise interrupt");
endmodule // pwm_interrupt_and_clear_control

// >>> inc/pwm_irq_pkg.sv
// Purpose: shared constants and carriers of the pwm interrupt/clear block
// Assumes: four channels, 32-bit avalon-mm data, byte addresses
// Notes: own registers sit above the last counter readback register
package pwm_irq_pkg;
    // ====================================================
    // geometry
    localparam int NUM_CH = 4;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ====================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_COUNTER_READBACK_0 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_COUNTER_READBACK_1 = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_COUNTER_READBACK_2 = 8'h2c;
    localparam logic [ADDR_W-1:0] OFF_COUNTER_READBACK_3 = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_CLEAR_POLARITY = 8'h3c;
    localparam logic [ADDR_W-1:0] OFF_CHANNEL_INTERRUPT_ENABLE = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_CHANNEL_INTERRUPT_FLAGS = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_LATCH_INDICATORS = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 8'h4c;
    localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 8'h50;

    // ====================================================
    // field positions
    localparam int POS_CLEAR_POLARITY_SELECT = 0;
    localparam int POS_RISING_LATCH_INDICATOR = 0;
    localparam int POS_FALLING_LATCH_INDICATOR = 4;
    localparam int POS_EV_ZERO = 0;
    localparam int POS_EV_RISE = 4;
    localparam int POS_EV_FALL = 8;
    localparam int EV_W = 12;

    // ====================================================
    // reset values
    localparam logic RST_CLEAR_POLARITY = 1'b0;
    localparam logic [NUM_CH-1:0] RST_IRQ_ENABLE = 4'h0;
    localparam logic [NUM_CH-1:0] RST_IRQ_FLAGS = 4'h0;
    localparam logic [NUM_CH-1:0] RST_LATCH_IND = 4'h0;
    localparam logic [EV_W-1:0] RST_EVENTS = 12'h000;
    localparam logic [DATA_W-1:0] RST_READDATA = 32'h0000_0000;

    // ====================================================
    // carriers and states
    typedef struct packed {
        logic [NUM_CH-1:0] zero_reached;
        logic [NUM_CH-1:0] rise_latched;
        logic [NUM_CH-1:0] fall_latched;
    } chan_events_s;

    typedef logic [NUM_CH-1:0][CNT_W-1:0] counters_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_e;
endpackage

// >>> testbench/pwm_interrupt_and_clear_control_test.sv
// Purpose: self-checking bench for the pwm interrupt and clear block
// Assumes: avalon-mm slave with waitrequest, events on clk_in
// Notes: byteenable at all lanes except one write with lane 0 off; expectations come from the map
`timescale 1ns/100ps
module pwm_interrupt_and_clear_control_test;
    import pwm_irq_pkg::*;

    // ==========================================================
    // stimulus and observation
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [ADDR_W-1:0] address_in = '0;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [DATA_W-1:0] writedata_in = '0;
    logic [3:0] byteenable_in = 4'hf;
    logic [DATA_W-1:0] readdata_out;
    logic waitrequest_out;
    chan_events_s events_in = '0;
    counters_t counters_in = '0;
    logic [NUM_CH-1:0] rising_latch_indicator_out;
    logic [NUM_CH-1:0] falling_latch_indicator_out;
    logic group_irq_out;
    logic event_irq_out;
    int err_total = 0;
    int compares = 0;
    logic [DATA_W-1:0] q;

    pwm_interrupt_and_clear_control i_dut (
        .clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in),
        .writedata_in(writedata_in), .byteenable_in(byteenable_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .events_in(events_in), .counters_in(counters_in),
        .rising_latch_indicator_out(rising_latch_indicator_out),
        .falling_latch_indicator_out(falling_latch_indicator_out),
        .group_irq_out(group_irq_out), .event_irq_out(event_irq_out));

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // holds the request until waitrequest is sampled low; watchdog bounds it
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        address_in <= a;
        writedata_in <= d;
        write_in <= wr;
        read_in <= ~wr;
        do begin
            @(posedge clk_in);
        end while (waitrequest_out !== 1'b0);
        q = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(exp, q);
    endtask

    // one-cycle event pulse, returns once its effect is visible
    task automatic pulse(input logic [3:0] z, input logic [3:0] r,
                         input logic [3:0] f);
        @(posedge clk_in);
        events_in <= '{zero_reached: z, rise_latched: r, fall_latched: f};
        @(posedge clk_in);
        events_in <= '0;
        @(posedge clk_in);
    endtask

    task automatic test_done();
        $display("counts: compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset_map();
        rd(OFF_CAPTURE_CLEAR_POLARITY, 32'h0);
        rd(OFF_CHANNEL_INTERRUPT_ENABLE, 32'h0);
        rd(OFF_CHANNEL_INTERRUPT_FLAGS, 32'h0);
        chk(32'h0, {31'h0, group_irq_out});
        xfer(1'b1, 8'h00, 32'hffff_ffff);
        rd(8'h00, 32'h0);
        // lane 0 off: the write must be ignored
        byteenable_in <= 4'he;
        xfer(1'b1, OFF_CHANNEL_INTERRUPT_ENABLE, 32'hf);
        byteenable_in <= 4'hf;
        rd(OFF_CHANNEL_INTERRUPT_ENABLE, 32'h0);
        $display("test reset_map done");
    endtask

    task automatic t_enable_flags();
        xfer(1'b1, OFF_CHANNEL_INTERRUPT_ENABLE, 32'hffff_fff5);
        rd(OFF_CHANNEL_INTERRUPT_ENABLE, 32'h5);
        pulse(4'hf, 4'h0, 4'h0);
        rd(OFF_CHANNEL_INTERRUPT_FLAGS, 32'h5);
        chk(32'h1, {31'h0, group_irq_out});
        xfer(1'b1, OFF_CHANNEL_INTERRUPT_FLAGS, 32'h0);
        rd(OFF_CHANNEL_INTERRUPT_FLAGS, 32'h5);
        xfer(1'b1, OFF_CHANNEL_INTERRUPT_FLAGS, 32'h1);
        rd(OFF_CHANNEL_INTERRUPT_FLAGS, 32'h4);
        chk(32'h1, {31'h0, group_irq_out});
        xfer(1'b1, OFF_CHANNEL_INTERRUPT_ENABLE, 32'ha);
        pulse(4'h8, 4'h0, 4'h0);
        rd(OFF_CHANNEL_INTERRUPT_FLAGS, 32'hc);
        xfer(1'b1, OFF_CHANNEL_INTERRUPT_FLAGS, 32'hc);
        rd(OFF_CHANNEL_INTERRUPT_FLAGS, 32'h0);
        @(posedge clk_in);
        chk(32'h0, {31'h0, group_irq_out});
        $display("test enable_flags done");
    endtask

    task automatic t_readback();
        counters_in <= {16'h0004, 16'h0c03, 16'hb002, 16'ha5f1};
        rd(OFF_COUNTER_READBACK_0, 32'ha5f1);
        rd(OFF_COUNTER_READBACK_1, 32'hb002);
        rd(OFF_COUNTER_READBACK_2, 32'h0c03);
        xfer(1'b1, OFF_COUNTER_READBACK_3, 32'hffff);
        rd(OFF_COUNTER_READBACK_3, 32'h0004);
        $display("test readback done");
    endtask

    task automatic t_latch_polarity();
        pulse(4'h0, 4'h5, 4'ha);
        chk(32'h5, {28'h0, rising_latch_indicator_out});
        chk(32'ha, {28'h0, falling_latch_indicator_out});
        rd(OFF_LATCH_INDICATORS, 32'ha5);
        // polarity 0: zero bits clear, ones keep
        xfer(1'b1, OFF_LATCH_INDICATORS, 32'ha4);
        rd(OFF_LATCH_INDICATORS, 32'ha4);
        xfer(1'b1, OFF_CAPTURE_CLEAR_POLARITY, 32'h1);
        rd(OFF_CAPTURE_CLEAR_POLARITY, 32'h1);
        xfer(1'b1, OFF_LATCH_INDICATORS, 32'h20);
        rd(OFF_LATCH_INDICATORS, 32'h84);
        chk(32'h8, {28'h0, falling_latch_indicator_out});
        chk(32'h4, {28'h0, rising_latch_indicator_out});
        $display("test latch_polarity done");
    endtask

    task automatic t_event_irq();
        xfer(1'b0, OFF_EVENT_STATUS, 32'h0);
        xfer(1'b1, OFF_EVENT_MASK, 32'h010);
        rd(OFF_EVENT_MASK, 32'h010);
        pulse(4'h0, 4'h0, 4'h1);
        chk(32'h0, {31'h0, event_irq_out});
        pulse(4'h0, 4'h1, 4'h0);
        chk(32'h1, {31'h0, event_irq_out});
        rd(OFF_EVENT_STATUS, 32'h110);
        rd(OFF_EVENT_STATUS, 32'h0);
        chk(32'h0, {31'h0, event_irq_out});
        // channel 0 zero with its enable off: event only, no flag
        xfer(1'b1, OFF_EVENT_MASK, 32'h001);
        pulse(4'h1, 4'h0, 4'h0);
        chk(32'h1, {31'h0, event_irq_out});
        rd(OFF_CHANNEL_INTERRUPT_FLAGS, 32'h0);
        rd(OFF_EVENT_STATUS, 32'h001);
        @(posedge clk_in);
        chk(32'h0, {31'h0, event_irq_out});
        $display("test event_irq done");
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        t_reset_map();
        t_enable_flags();
        t_readback();
        t_latch_polarity();
        t_event_irq();
        test_done();
    end

    // all tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        test_done();
    end
endmodule // pwm_interrupt_and_clear_control_test
